// [bench/scb_phase_src.sv]
// two-phase clock source standing in for the analog array timing
`timescale 1ns/10ps
module scb_phase_src #(
  parameter int HI = 16
) (
  input wire logic clk,
  output logic ph1,
  output logic ph2
);
  localparam logic [7:0] H = 8'(HI);
  logic [7:0] cnt_r = 8'h00;
  always_ff @(posedge clk) begin
    cnt_r <= (cnt_r == H + H + 8'h07) ? 8'h00 : cnt_r + 8'h01;
  end
  // four idle cycles after each phase so the two never overlap
  assign ph1 = cnt_r < H;
  assign ph2 = cnt_r >= H + 8'h04 && cnt_r < H + H + 8'h04;
endmodule

// [bench/scb_top_assertions.sv]
// concurrent checks on the type b control block ports
`timescale 1ns/10ps
`include "scb_consts.svh"
module scb_top_assertions (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic [23:0] FEEDBACK_CAP_SIZE,
  input wire logic [19:0] A_CAP_UNITS,
  input wire logic [19:0] B_CAP_UNITS,
  input wire logic [23:0] A_BRANCH_INPUT_SELECT,
  input wire logic [3:0] A_SELECT_RESERVED,
  input wire logic [3:0] INT_PHASE_ONE,
  input wire logic [3:0] INT_PHASE_TWO,
  input wire logic [3:0] A_INPUT_SAMPLE,
  input wire logic [3:0] A_REF_SAMPLE,
  input wire logic [3:0] OUT_BUS_CONNECT,
  input wire logic [3:0] COLUMN_BUS_OE_N
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);
  sequence wr0_s;
    WR && ADDR == `SCB_BLK11_CTRL0;
  endsequence
  sequence wr1_s;
    WR && ADDR == `SCB_BLK11_CTRL1;
  endsequence
  a_fb_size: assert property (
    wr0_s |=> ##1 FEEDBACK_CAP_SIZE[5:0] == ($past(WDATA[7], 2) ? 6'h20 : 6'h10))
    else $error("feedback size wrong");
  a_a_cap_count: assert property (
    wr0_s |=> ##1 A_CAP_UNITS[4:0] == $past(WDATA[4:0], 2)) else $error("a cap wrong");
  a_b_cap_count: assert property (
    wr1_s |=> ##1 B_CAP_UNITS[4:0] == $past(WDATA[4:0], 2)) else $error("b cap wrong");
  a_sel_decode: assert property (
    wr1_s |=> ##1 A_BRANCH_INPUT_SELECT[5:0] == ($past(WDATA[7:5], 2) > 3'h5 ? 6'h00
      : 6'h01 << $past(WDATA[7:5], 2))) else $error("input select wrong");
  a_sel_reserved: assert property (
    wr1_s |=> ##1 A_SELECT_RESERVED[0] == ($past(WDATA[7:6], 2) == 2'h3))
    else $error("reserved flag wrong");
  a_phase_excl: assert property (
    (INT_PHASE_ONE & INT_PHASE_TWO) == 4'h0) else $error("internal phases overlap");
  a_sample_excl: assert property (
    (A_INPUT_SAMPLE & A_REF_SAMPLE) == 4'h0) else $error("input and reference overlap");
  a_connect_ph2: assert property (
    OUT_BUS_CONNECT[0] |-> INT_PHASE_TWO[0] || $past(INT_PHASE_TWO[0]))
    else $error("output bus joined outside phase two");
  a_read_idle: assert property (
    !RD |=> RDATA == 8'h00) else $error("read data outside read slot");
  a_bus_float: assert property (
    WR && ADDR == `SCB_BUS_ENABLES && !WDATA[0] |=> ##2 COLUMN_BUS_OE_N[0])
    else $error("column bus driven while disabled");
endmodule
bind scb_top scb_top_assertions scb_top_assertions_inst (.REF_CLK, .NRST, .ADDR,
  .WDATA, .WR, .RD, .RDATA, .FEEDBACK_CAP_SIZE, .A_CAP_UNITS, .B_CAP_UNITS,
  .A_BRANCH_INPUT_SELECT, .A_SELECT_RESERVED, .INT_PHASE_ONE, .INT_PHASE_TWO,
  .A_INPUT_SAMPLE, .A_REF_SAMPLE, .OUT_BUS_CONNECT, .COLUMN_BUS_OE_N);

// [bench/tb.sv]
// self-checking bench for the type b control block
`timescale 1ns/10ps
`include "scb_consts.svh"
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [3:0] cmp_in = 4'h0;
  logic ph1, ph2;
  logic [7:0] rdata;
  logic [23:0] fb, asel;
  logic [19:0] a_cap_units, b_cap_units;
  logic [3:0] rsvd, ip1, ip2, isam, rsam, conn, oe_n, comparator_column_bus;
  logic [7:0] regs [8] = '{`SCB_BLK11_CTRL0, `SCB_BLK11_CTRL1, `SCB_BLK13_CTRL0,
    `SCB_BLK13_CTRL1, `SCB_BLK20_CTRL0, `SCB_BLK20_CTRL1, `SCB_BLK22_CTRL0, `SCB_BLK22_CTRL1};
  int n_errors = 0;
  int checks = 0;
  int p2, c, dr;
  always #2 clk = ~clk;
  scb_phase_src scb_phase_src_inst (.clk(clk), .ph1(ph1), .ph2(ph2));
  scb_top scb_top_inst (.REF_CLK(clk), .NRST(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .PHASE_ONE_CLOCK(ph1), .PHASE_TWO_CLOCK(ph2),
    .COMPARATOR_LEVEL(cmp_in),
    .FEEDBACK_CAP_SIZE(fb), .A_CAP_UNITS(a_cap_units), .B_CAP_UNITS(b_cap_units),
    .A_BRANCH_INPUT_SELECT(asel), .A_SELECT_RESERVED(rsvd), .INT_PHASE_ONE(ip1),
    .INT_PHASE_TWO(ip2), .A_INPUT_SAMPLE(isam), .A_REF_SAMPLE(rsam), .OUT_BUS_CONNECT(conn),
    .COLUMN_BUS_OE_N(oe_n), .COMPARATOR_COLUMN_BUS(comparator_column_bus));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // decode outputs lag the register by one edge, so settle before returning
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(24'(rdata), 24'(exp), "read data");
  endtask
  task automatic mid_ph1;
    int k;
    for (k = 0; k < 60 && ph1 === 1'b1; k++) @(posedge clk);
    for (k = 0; k < 60 && ph1 !== 1'b1; k++) @(posedge clk);
    repeat (10) @(negedge clk);
  endtask
  // one full 40-cycle phase period, after two periods to let the length count settle
  task automatic win;
    p2 = 0;
    c = 0;
    dr = 0;
    repeat (80) @(posedge clk);
    repeat (40) begin
      @(negedge clk);
      p2 += int'(ip2[0] === 1'b1);
      c += int'(conn[0] === 1'b1);
      dr += int'(oe_n[0] === 1'b0);
    end
  endtask
  initial begin
    #40000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    int i;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check(fb, 24'h410410, "fb reset");
    check(asel, 24'h041041, "sel reset");
    for (i = 0; i < 8; i++) rd_chk(regs[i], 8'h00);
    $display("test reset done");
    for (i = 0; i < 9; i++) wr_reg(i < 8 ? regs[i] : 8'h80, 8'hff);
    check(fb, 24'h820820, "fb large");
    check(24'(a_cap_units), 24'hfffff, "a cap full");
    check(24'(b_cap_units), 24'hfffff, "b cap full");
    check(24'(rsvd), 24'hf, "reserved flags");
    check(asel, 24'h0, "sel reserved");
    for (i = 0; i < 8; i++) rd_chk(regs[i], 8'hff);
    rd_chk(8'h80, 8'h00);
    for (i = 0; i < 8; i++) wr_reg(regs[i], 8'(8'h11 * i));
    for (i = 0; i < 8; i++) rd_chk(regs[i], 8'(8'h11 * i));
    check(24'(a_cap_units), 24'h31040, "a cap blocks");
    check(24'(b_cap_units), 24'hbd671, "b cap blocks");
    check(asel, 24'h204081, "sel blocks");
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      wr_reg(`SCB_BLK11_CTRL1, 8'(i << 5));
      check(24'(asel[5:0]), i > 5 ? 24'h0 : 24'(1 << i), "sel code");
      check(24'(rsvd[0]), 24'(i > 5), "reserved code");
    end
    $display("test select done");
    wr_reg(`SCB_BUS_ENABLES, 8'hff);
    wr_reg(`SCB_BLK11_CTRL0, 8'h00);
    mid_ph1;
    check(24'({ip1[0], ip2[0], isam[0], rsam[0]}), 24'ha, "phase plain");
    wr_reg(`SCB_BLK11_CTRL0, 8'h20);
    mid_ph1;
    check(24'({ip1[0], ip2[0], isam[0], rsam[0]}), 24'h9, "sign set");
    wr_reg(`SCB_BLK11_CTRL0, 8'h40);
    mid_ph1;
    check(24'({ip1[0], ip2[0], isam[0], rsam[0]}), 24'h5, "phase swapped");
    wr_reg(`SCB_BLK11_CTRL0, 8'h00);
    win;
    check(24'(p2), 24'd16, "phase two length");
    check(24'(c), 24'd8, "late half");
    check(24'(dr), 24'd8, "gated drive");
    wr_reg(`SCB_GLOBAL_CTRL, 8'h40);
    win;
    check(24'(c), 24'(p2), "hold disabled");
    wr_reg(`SCB_GLOBAL_CTRL, 8'h00);
    wr_reg(`SCB_BLK11_CTRL0, 8'h40);
    win;
    check(24'(c), 24'(p2), "whole phase two");
    check(24'(dr), 24'd40, "steady drive");
    $display("test phases done");
    @(posedge clk);
    cmp_in <= 4'hf;
    win;
    check(24'(comparator_column_bus), 24'hf, "comparator high");
    wr_reg(`SCB_BUS_ENABLES, 8'h0f);
    win;
    check(24'(comparator_column_bus), 24'h0, "comparator idle");
    wr_reg(`SCB_BUS_ENABLES, 8'hf0);
    check(24'(oe_n), 24'hf, "column float");
    // blocks 11, 20, 22 have the phase bit set, block 13 has it clear
    mid_ph1;
    @(posedge clk);
    cmp_in <= 4'h0;
    repeat (10) @(negedge clk);
    check(24'(comparator_column_bus), 24'hf, "comparator held");
    repeat (8) @(negedge clk);
    check(24'(comparator_column_bus), 24'h2, "capture edges");
    $display("test buses done");
    tally_and_finish;
  end
endmodule

// [logic/scb_blk_phase.sv]
// per-block clock phasing, output gating and comparator latch
`timescale 1ns/10ps
module scb_blk_phase (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ph1,
  input wire logic ph2,
  input wire logic ph1_rise,
  input wire logic ph1_fall,
  input wire logic ph2_rise,
  input wire logic ph2_fall,
  input wire logic late_ph2,
  input wire logic sh_dis,
  input wire logic phase_inv,
  input wire logic a_sign,
  input wire logic bus_en,
  input wire logic cmp_en,
  input wire logic cmp_lvl,
  output logic int_ph1_r,
  output logic int_ph2_r,
  output logic in_sample_r,
  output logic ref_sample_r,
  output logic out_connect_r,
  output logic col_oe_n_r,
  output logic cmp_bus_r,
  output logic cmp_held_r
);
  logic int_ph1;
  logic int_ph2;
  logic hold_win;
  logic capture;
  logic present;
  logic cmp_cap_r;

  assign int_ph1 = phase_inv ? ph2 : ph1;
  assign int_ph2 = phase_inv ? ph1 : ph2;

  assign hold_win = (sh_dis | phase_inv) ? int_ph2 : (ph2 & late_ph2);

  assign capture = phase_inv ? ph1_fall : ph2_fall;
  assign present = phase_inv ? ph2_rise : ph1_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_ph1_r <= 1'b0;
      int_ph2_r <= 1'b0;
    end else begin
      int_ph1_r <= int_ph1;
      int_ph2_r <= int_ph2;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_sample_r <= 1'b0;
      ref_sample_r <= 1'b0;
    end else begin
      in_sample_r <= a_sign ? int_ph2 : int_ph1;
      ref_sample_r <= a_sign ? int_ph1 : int_ph2;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_connect_r <= 1'b0;
      col_oe_n_r <= 1'b1;
    end else begin
      out_connect_r <= bus_en & hold_win;
      // column bus drive, floats when disabled
      col_oe_n_r <= ~(bus_en & (phase_inv | hold_win));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_cap_r <= 1'b0;
      cmp_held_r <= 1'b0;
    end else begin
      if (capture) begin
        cmp_cap_r <= cmp_lvl;
      end
      if (present) begin
        cmp_held_r <= cmp_cap_r;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_bus_r <= 1'b0;
    end else begin
      cmp_bus_r <= cmp_en & (present ? cmp_cap_r : cmp_held_r);
    end
  end
endmodule

// [logic/scb_top.sv]
// register file, phase tracking and capacitor/mux decode for four type b blocks
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`include "scb_consts.svh"

// How it works
// - feedback size bit picks 16 or 32
// - phase bit swaps internal phase clocks
// - output bus joined late phase two only
// - phase bit set joins whole phase two
// - global disable joins whole phase two
// - comparator latch captures, presents, holds steady
// - phase bit picks capture and present edges
// - sign bit swaps input and reference phase
// - a capacitor field is plain count
// - b capacitor field is plain count
// - input select codes 110/111 reserved
// - input select routes source, 100 high ref
// - phase bit and enable shape column drive
// - enable clear floats column bus
// - undriven comparator bus reads low
module scb_top #(
  parameter int NBLK = `SCB_NBLK,
  parameter int CNT_W = `SCB_PH2_CNT_W
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic PHASE_ONE_CLOCK,
  input wire logic PHASE_TWO_CLOCK,
  input wire logic [3:0] COMPARATOR_LEVEL,
  output logic [23:0] FEEDBACK_CAP_SIZE,
  output logic [19:0] A_CAP_UNITS,
  output logic [19:0] B_CAP_UNITS,
  output logic [23:0] A_BRANCH_INPUT_SELECT,
  output logic [3:0] A_SELECT_RESERVED,
  output logic [3:0] INT_PHASE_ONE,
  output logic [3:0] INT_PHASE_TWO,
  output logic [3:0] A_INPUT_SAMPLE,
  output logic [3:0] A_REF_SAMPLE,
  output logic [3:0] OUT_BUS_CONNECT,
  output logic [3:0] COLUMN_BUS_OE_N,
  output logic [3:0] COMPARATOR_COLUMN_BUS
);

  logic rst_s1_r;
  logic rst_n_r;

  // reset enters asynchronously, is released through two flops
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // pin synchronisers: three stages, level accepted when stages two and three agree
  logic [5:0] pin_in;
  logic [5:0] sy1_r;
  logic [5:0] sy2_r;
  logic [5:0] sy3_r;
  logic [5:0] pin_f_r;

  assign pin_in = {COMPARATOR_LEVEL, PHASE_TWO_CLOCK, PHASE_ONE_CLOCK};

  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sy1_r <= 6'h00;
      sy2_r <= 6'h00;
      sy3_r <= 6'h00;
    end else begin
      sy1_r <= pin_in;
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end

  // the filter looks only at stages two and three, never the first
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_f_r <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (sy2_r[i] == sy3_r[i]) begin
          pin_f_r[i] <= sy2_r[i];
        end
      end
    end
  end

  logic ph1;
  logic ph2;
  logic ph1_d_r;
  logic ph2_d_r;
  logic ph1_rise;
  logic ph1_fall;
  logic ph2_rise;
  logic ph2_fall;

  assign ph1 = pin_f_r[0];
  assign ph2 = pin_f_r[1];

  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ph1_d_r <= 1'b0;
      ph2_d_r <= 1'b0;
    end else begin
      ph1_d_r <= ph1;
      ph2_d_r <= ph2;
    end
  end

  assign ph1_rise = ph1 & ~ph1_d_r;
  assign ph1_fall = ~ph1 & ph1_d_r;
  assign ph2_rise = ph2 & ~ph2_d_r;
  assign ph2_fall = ~ph2 & ph2_d_r;

  // external phase tracker; phase two length is measured so its second half can be found
  scb_pkg::scb_phase_t phase_r;
  logic [CNT_W-1:0] ph2_cnt_r;
  logic [CNT_W-1:0] ph2_len_r;
  logic late_ph2;

  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      phase_r <= scb_pkg::SCB_PH_NONE;
    end else begin
      unique case (phase_r)
        scb_pkg::SCB_PH_NONE: begin
          if (ph2) begin
            phase_r <= scb_pkg::SCB_PH_TWO;
          end else if (ph1) begin
            phase_r <= scb_pkg::SCB_PH_ONE;
          end
        end
        scb_pkg::SCB_PH_ONE: begin
          if (!ph1) begin
            phase_r <= ph2 ? scb_pkg::SCB_PH_TWO : scb_pkg::SCB_PH_NONE;
          end
        end
        scb_pkg::SCB_PH_TWO: begin
          if (!ph2) begin
            phase_r <= ph1 ? scb_pkg::SCB_PH_ONE : scb_pkg::SCB_PH_NONE;
          end
        end
        default: begin
          phase_r <= scb_pkg::SCB_PH_NONE;
        end
      endcase
    end
  end

  // counter saturates so a stopped clock cannot wrap it
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ph2_cnt_r <= '0;
    end else if (ph2_rise) begin
      ph2_cnt_r <= '0;
    end else if (ph2 && ph2_cnt_r != {CNT_W{1'b1}}) begin
      ph2_cnt_r <= ph2_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ph2_len_r <= '0;
    end else if (ph2_fall) begin
      ph2_len_r <= ph2_cnt_r;
    end
  end

  // second half uses last measured length
  assign late_ph2 = (phase_r == scb_pkg::SCB_PH_TWO) && (ph2_cnt_r >= (ph2_len_r >> 1));

  // register file: each block owns two control bytes
  logic [7:0] ctrl0_r [NBLK];
  logic [7:0] ctrl1_r [NBLK];
  logic [7:0] bus_en_r;
  logic [7:0] glob_r;
  logic [7:0] status;
  logic [7:0] rd_mux;
  logic [3:0] cmp_held;

  localparam logic [7:0] CTRL0_OFS [4] = '{`SCB_BLK11_CTRL0, `SCB_BLK13_CTRL0,
                                          `SCB_BLK20_CTRL0, `SCB_BLK22_CTRL0};
  localparam logic [7:0] CTRL1_OFS [4] = '{`SCB_BLK11_CTRL1, `SCB_BLK13_CTRL1,
                                          `SCB_BLK20_CTRL1, `SCB_BLK22_CTRL1};

  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int i = 0; i < NBLK; i++) begin
        ctrl0_r[i] <= `SCB_CTRL_RESET;
        ctrl1_r[i] <= `SCB_CTRL_RESET;
      end
    end else if (WR) begin
      for (int i = 0; i < NBLK; i++) begin
        if (ADDR == CTRL0_OFS[i]) begin
          ctrl0_r[i] <= WDATA;
        end
        if (ADDR == CTRL1_OFS[i]) begin
          ctrl1_r[i] <= WDATA;
        end
      end
    end
  end

  // low nibble enables column bus drive, high nibble comparator drive
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      bus_en_r <= `SCB_CTRL_RESET;
      glob_r <= `SCB_CTRL_RESET;
    end else if (WR) begin
      if (ADDR == `SCB_BUS_ENABLES) begin
        bus_en_r <= WDATA;
      end
      if (ADDR == `SCB_GLOBAL_CTRL) begin
        glob_r <= WDATA;
      end
    end
  end

  assign status = {2'b00, ph2, ph1, cmp_held};

  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < NBLK; i++) begin
      if (ADDR == CTRL0_OFS[i]) begin
        rd_mux = ctrl0_r[i];
      end
      if (ADDR == CTRL1_OFS[i]) begin
        rd_mux = ctrl1_r[i];
      end
    end
    if (ADDR == `SCB_BUS_ENABLES) begin
      rd_mux = bus_en_r;
    end
    if (ADDR == `SCB_GLOBAL_CTRL) begin
      rd_mux = glob_r;
    end
    if (ADDR == `SCB_STATUS) begin
      rd_mux = status;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge REF_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? rd_mux : 8'h00;
    end
  end

  // capacitor and input mux decode, registered per block
  for (genvar b = 0; b < NBLK; b++) begin : g_blk
    logic [2:0] a_branch_input_select;
    logic [5:0] src;
    logic rsvd;

    assign a_branch_input_select = ctrl1_r[b][`SCB_A_BRANCH_INPUT_SELECT_MSB:`SCB_A_BRANCH_INPUT_SELECT_LSB];

    always_comb begin
      src = 6'h00;
      rsvd = 1'b0;
      if (a_branch_input_select == `SCB_A_BRANCH_INPUT_SELECT_RSVD_A || a_branch_input_select == `SCB_A_BRANCH_INPUT_SELECT_RSVD_B) begin
        rsvd = 1'b1;
      end else begin
        src[a_branch_input_select] = 1'b1;
      end
    end

    always_ff @(posedge REF_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
        FEEDBACK_CAP_SIZE[b*6 +: 6] <= `SCB_FB_UNITS_SMALL;
        A_CAP_UNITS[b*5 +: 5] <= 5'h00;
        B_CAP_UNITS[b*5 +: 5] <= 5'h00;
        A_BRANCH_INPUT_SELECT[b*6 +: 6] <= 6'h01;
        A_SELECT_RESERVED[b] <= 1'b0;
      end else begin
        FEEDBACK_CAP_SIZE[b*6 +: 6] <= ctrl0_r[b][`SCB_FB_CAP_BIT] ?
          `SCB_FB_UNITS_LARGE : `SCB_FB_UNITS_SMALL;
        A_CAP_UNITS[b*5 +: 5] <= ctrl0_r[b][`SCB_CAP_MSB:0];
        B_CAP_UNITS[b*5 +: 5] <= ctrl1_r[b][`SCB_CAP_MSB:0];
        A_BRANCH_INPUT_SELECT[b*6 +: 6] <= src;
        A_SELECT_RESERVED[b] <= rsvd;
      end
    end

    // each block driven by its own bytes
    scb_blk_phase u_phase (
      .clk(REF_CLK),
      .rst_n(rst_n_r),
      .ph1(ph1),
      .ph2(ph2),
      .ph1_rise(ph1_rise),
      .ph1_fall(ph1_fall),
      .ph2_rise(ph2_rise),
      .ph2_fall(ph2_fall),
      .late_ph2(late_ph2),
      .sh_dis(glob_r[`SCB_SH_DIS_BIT]),
      .phase_inv(ctrl0_r[b][`SCB_PHASE_INV_BIT]),
      .a_sign(ctrl0_r[b][`SCB_A_SIGN_BIT]),
      .bus_en(bus_en_r[b]),
      .cmp_en(bus_en_r[b+4]),
      .cmp_lvl(pin_f_r[b+2]),
      .int_ph1_r(INT_PHASE_ONE[b]),
      .int_ph2_r(INT_PHASE_TWO[b]),
      .in_sample_r(A_INPUT_SAMPLE[b]),
      .ref_sample_r(A_REF_SAMPLE[b]),
      .out_connect_r(OUT_BUS_CONNECT[b]),
      .col_oe_n_r(COLUMN_BUS_OE_N[b]),
      .cmp_bus_r(COMPARATOR_COLUMN_BUS[b]),
      .cmp_held_r(cmp_held[b])
    );
  end

endmodule

// [shared/scb_consts.svh]
// register offsets, field positions, reset values and counts for the type b control block
`ifndef SCB_CONSTS_SVH
`define SCB_CONSTS_SVH

`define SCB_ADDR_W 8
`define SCB_DATA_W 8
`define SCB_NBLK 4

`define SCB_BLK11_CTRL0 8'h84
`define SCB_BLK11_CTRL1 8'h85
`define SCB_BLK13_CTRL0 8'h8c
`define SCB_BLK13_CTRL1 8'h8d
`define SCB_BLK20_CTRL0 8'h90
`define SCB_BLK20_CTRL1 8'h91
`define SCB_BLK22_CTRL0 8'h98
`define SCB_BLK22_CTRL1 8'h99
`define SCB_BUS_ENABLES 8'ha0
`define SCB_GLOBAL_CTRL 8'ha1
`define SCB_STATUS 8'ha2

`define SCB_CTRL_RESET 8'h00

`define SCB_FB_CAP_BIT 7
`define SCB_PHASE_INV_BIT 6
`define SCB_A_SIGN_BIT 5
`define SCB_CAP_MSB 4
`define SCB_A_BRANCH_INPUT_SELECT_MSB 7
`define SCB_A_BRANCH_INPUT_SELECT_LSB 5
`define SCB_SH_DIS_BIT 6

`define SCB_FB_UNITS_SMALL 6'h10
`define SCB_FB_UNITS_LARGE 6'h20
`define SCB_FB_UNITS_W 6

`define SCB_A_BRANCH_INPUT_SELECT_HIGH_REF 3'h4
`define SCB_A_BRANCH_INPUT_SELECT_RSVD_A 3'h6
`define SCB_A_BRANCH_INPUT_SELECT_RSVD_B 3'h7
`define SCB_ASRC_W 6

`define SCB_PH2_CNT_W 10

`endif

// [shared/scb_pkg.sv]
// types shared by the type b control block files
package scb_pkg;

  typedef enum logic [2:0] {
    SCB_PH_NONE = 3'b001,
    SCB_PH_ONE  = 3'b010,
    SCB_PH_TWO  = 3'b100
  } scb_phase_t;

  typedef logic [7:0] scb_reg_t;

endpackage
